// ==== core/fpbs_consts.svh ====
// Purpose: named constants for the protection-bit flash sequencer
// Assumes: 32-bit register port, byte addresses
// Notes: definitions only
`ifndef FPBS_CONSTS_SVH
`define FPBS_CONSTS_SVH
`define FPBS_CSR_ADDR 32'h0000_0000
`define FPBS_CMD_BASE 32'h0000_0100
`define FPBS_UNLOCK_A 8'hAA
`define FPBS_UNLOCK_B 8'h55
`define FPBS_PROG_CODE 8'h9A
`define FPBS_ERASE_CODE 8'h6A
`define FPBS_RESET_CODE 8'hF0
`define FPBS_ADDR_A 16'h5500
`define FPBS_ADDR_B 16'hAA00
`define FPBS_ALL_PROT 4'hF
`define FPBS_PROG_NS 20000
`define FPBS_ARRAY_ERASE_NS 100000
`define FPBS_BIT_ERASE_NS 40000
`define FPBS_CLK_NS 20
`define FPBS_RDY_BIT 0
`define FPBS_ROM_BIT 2
`define FPBS_PROT_LSB 4
`define FPBS_SEL_LSB 4
`endif

// ==== core/fpbs_pkg.sv ====
// Purpose: types for the protection-bit flash sequencer
// Assumes: nothing
// Notes: one-hot sequencer states
package fpbs_pkg;
  typedef enum logic [4:0] {
    FPBS_IDLE = 5'h01,
    FPBS_UNLK = 5'h02,
    FPBS_BUSY = 5'h04,
    FPBS_FAIL = 5'h08,
    FPBS_LOCK = 5'h10
  } fpbs_state_e;
  typedef enum logic [1:0] {
    FPBS_OP_PROG = 2'h0,
    FPBS_OP_PAIR = 2'h1,
    FPBS_OP_FULL = 2'h2
  } fpbs_op_e;
endpackage : fpbs_pkg

// ==== core/fpbs_cmd_if.sv ====
// Purpose: carrier between the decoder and the sequencer
// Assumes: single clock
// Notes: cmd_valid is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface fpbs_cmd_if;
  logic cmd_valid; // Decoded write cycle
  logic [7:0] cmd_data; // Low byte of write data
  logic [15:0] cmd_addr; // Low half of address
  logic [31:0] cmd_full_addr; // Whole address
  modport src (output cmd_valid, output cmd_data, output cmd_addr, output cmd_full_addr);
  modport dst (input cmd_valid, input cmd_data, input cmd_addr, input cmd_full_addr);
endinterface : fpbs_cmd_if
`default_nettype wire

// ==== core/fpbs_cmd_decode.sv ====
// Purpose: pick command-space writes from the register port
// Assumes: command space begins at FPBS_CMD_BASE
// Notes: combinational; adds no latency
`timescale 1ns/1ps
`default_nettype none
`include "fpbs_consts.svh"
module fpbs_cmd_decode
  import fpbs_pkg::*;
(
  input wire logic wr_en,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  fpbs_cmd_if.src cmd
);
  // Command space is everything at or above the base
  wire in_cmd_space = (addr >= `FPBS_CMD_BASE);
  assign cmd.cmd_valid = wr_en & in_cmd_space;
  assign cmd.cmd_data = wdata[7:0];
  assign cmd.cmd_addr = addr[15:0];
  assign cmd.cmd_full_addr = addr;
endmodule : fpbs_cmd_decode
`default_nettype wire

// ==== core/fpbs_timer.sv ====
// Purpose: down-counter timing an automatic operation
// Assumes: load and run from the same clock
// Notes: done pulses one cycle when the count runs out
`timescale 1ns/1ps
`default_nettype none
module fpbs_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] remain; // Cycles still to run
  logic running; // Counting in progress
  // Count down; stop on load of zero too
  always_ff @(posedge clk) begin
    if (rst) begin
      remain <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (load) begin
        remain <= count;
        running <= 1'b1;
      end else if (running) begin
        if (remain <= {{(W-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule : fpbs_timer
`default_nettype wire

// ==== core/fpbs_sequencer.sv ====
// Purpose: protection-bit program/erase sequencer with status register
// Assumes: CPU keeps its write spacing; reads return one cycle later
// Notes: array and protection cells are abstracted as timed operations
// Notes: ce low freezes every register, the timer included
// Notes: the far-side array sees only the strobe and the two deny flags
// Notes on behaviour
// [RULE1] Four protection bits, set singly, seventh cycle
// [RULE2] Protected block refuses write and erase
// [RULE3] Busy operation ignores commands; hard reset only
// [RULE4] All protected: outside reads blocked, reads F
// [RULE5] All protected: only protection erase accepted
// [RULE6] Soft reset ignored in seventh program cycle
// [RULE7] Ready flag drops entering seventh program cycle
// [RULE8] Erase behaviour depends on prior protection state
// [RULE9] All set: erase array, then bits
// [RULE10] Full erase done: status reads 0x01
// [RULE11] Only hard reset aborts post-seventh operation
// [RULE12] Otherwise erase selected pair of bits
// [RULE13] Pair erase done: those bits read zero
// [RULE14] Normal end returns to read mode
// [RULE15] Ready low while busy, high after
// [RULE16] Bits 7..4 show block 3..0 protection
// [RULE17] Bit 2 is rom kind, flash zero
// [RULE18] Failure holds ready low until hard reset
// [RULE19] CPU sends AA 55 code AA 55 code code
// [RULE20] CPU spaces command writes by 15 clocks
// [RULE21] Other bits read zero; writes ignored
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "fpbs_consts.svh"
module fpbs_sequencer
  import fpbs_pkg::*;
#(
  parameter int PROG_CYCLES = (`FPBS_PROG_NS + `FPBS_CLK_NS - 1) / `FPBS_CLK_NS,
  parameter int ARRAY_CYCLES = (`FPBS_ARRAY_ERASE_NS + `FPBS_CLK_NS - 1) / `FPBS_CLK_NS,
  parameter int PAIR_CYCLES = (`FPBS_BIT_ERASE_NS + `FPBS_CLK_NS - 1) / `FPBS_CLK_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [3:0] target_block,
  input wire logic target_is_write,
  input wire logic target_is_erase,
  input wire logic outside_read,
  input wire logic op_fault,
  output logic [31:0] rdata,
  output logic [3:0] block_protect_flags,
  output logic ready_busy_flag,
  output logic block_access_denied,
  output logic outside_read_denied,
  output logic array_erase_pulse
);
  // Timer width; the longest phase must fit in it
  // Default timings need at most 5000 cycles, well inside 16 bits
  localparam int TW = 16;
  // Carrier between decoder and sequence matcher
  fpbs_cmd_if cmd_bus ();
  fpbs_state_e state; // Sequencer state
  fpbs_state_e next_state; // Next sequencer state
  fpbs_op_e op; // Operation under way
  logic [2:0] cyc; // Command cycles already matched
  logic [7:0] code; // Program or erase code of this sequence
  logic [3:0] sel_mask; // Bits chosen at the seventh cycle
  logic full_phase2; // Array done, bits erasing now
  logic tmr_load; // Start timer
  logic [TW-1:0] tmr_count; // Timer load value
  logic tmr_done; // Timer expired
  logic [3:0] prot_done; // Pending change of flags

  // Split write traffic into command space
  // Decoder is combinational, so a write is matched on the edge it is taken
  fpbs_cmd_decode u_dec (
    .wr_en(wr_en),
    .addr(addr),
    .wdata(wdata),
    .cmd(cmd_bus.src)
  );

  // Shared operation timer
  // A load restarts it even while it is still running
  fpbs_timer #(.W(TW)) u_tmr (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // Expected address/data for each unlock cycle
  // Only the low address half is compared for the unlock cycles
  // The seventh cycle may use any command-space address
  wire [7:0] d = cmd_bus.cmd_data;
  wire [15:0] a = cmd_bus.cmd_addr;
  wire v = cmd_bus.cmd_valid;
  wire is_a_cyc = (a == `FPBS_ADDR_A) && (d == `FPBS_UNLOCK_A);
  wire is_b_cyc = (a == `FPBS_ADDR_B) && (d == `FPBS_UNLOCK_B);
  wire is_code = (a == `FPBS_ADDR_A) && ((d == `FPBS_PROG_CODE) || (d == `FPBS_ERASE_CODE));
  wire is_soft_reset = (d == `FPBS_RESET_CODE);
  wire all_prot = (block_protect_flags == `FPBS_ALL_PROT);
  // Seventh cycle: code repeated, address carries the bit select
  wire seventh = v && (cyc == 3'h6) && (d == code);
  wire [1:0] bit_sel = cmd_bus.cmd_full_addr[`FPBS_SEL_LSB+1:`FPBS_SEL_LSB];
  // Per-cycle match of the seven-cycle sequence
  wire step_ok = ((cyc == 3'h0) && is_a_cyc) || ((cyc == 3'h1) && is_b_cyc) ||
                 ((cyc == 3'h2) && is_code) ||
                 ((cyc == 3'h3) && is_a_cyc) || ((cyc == 3'h4) && is_b_cyc) ||
                 ((cyc == 3'h5) && (a == `FPBS_ADDR_A) && (d == code));
  // While fully locked only the erase code may open a sequence
  wire code_allowed = !all_prot || (d == `FPBS_ERASE_CODE); // [RULE5]
  wire [3:0] one_bit = 4'h1 << bit_sel;
  wire [3:0] pair_bits = bit_sel[1] ? 4'hC : 4'h3; // [RULE12]

  // The matcher walks the seven cycles in order; a write that does not
  // fit the expected step throws the sequence away without a trace.
  // Spacing between writes is the CPU's duty; nothing here checks it.
  // Next-state decode
  always_comb begin
    next_state = state;
    unique case (state)
      FPBS_IDLE: begin
        if (v && is_a_cyc) next_state = FPBS_UNLK;
      end
      FPBS_UNLK: begin
        // Seventh cycle cannot be cancelled by soft reset
        if (seventh) next_state = FPBS_BUSY; // [RULE6]
        else if (v && is_soft_reset) next_state = FPBS_IDLE;
        else if (v && !(step_ok && ((cyc != 3'h2) || code_allowed))) next_state = FPBS_IDLE;
      end
      FPBS_BUSY: begin
        // Commands are not looked at here at all
        if (op_fault) next_state = FPBS_FAIL; // [RULE3]
        else if (tmr_done && !(op == FPBS_OP_FULL && !full_phase2)) next_state = FPBS_IDLE; // [RULE14]
      end
      // Stuck here until rst; commands and soft reset are ignored
      FPBS_FAIL: next_state = FPBS_FAIL; // [RULE18]
      // Reserved state, never entered by this sequencer
      FPBS_LOCK: next_state = FPBS_LOCK;
      // Illegal one-hot code recovers to idle
      default: next_state = FPBS_IDLE;
    endcase
  end

  // Timer load for the operation phases
  // The full erase runs two timed phases back to back on one timer;
  // the second load happens on the cycle the first phase reports done.
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = '0;
    if (state == FPBS_UNLK && seventh) begin
      tmr_load = 1'b1;
      if (code == `FPBS_PROG_CODE) tmr_count = TW'(PROG_CYCLES);
      else if (all_prot) tmr_count = TW'(ARRAY_CYCLES); // [RULE9]
      else tmr_count = TW'(PAIR_CYCLES);
    end else if (state == FPBS_BUSY && tmr_done && op == FPBS_OP_FULL && !full_phase2) begin
      tmr_load = 1'b1;
      tmr_count = TW'(PAIR_CYCLES);
    end
  end

  // Flags that change when an operation ends normally
  // They move only on the cycle the timer ends a phase, or on a hard
  // reset, which clears them to zero even in the middle of an operation.
  // A fault freezes them as well, since the timer result is then unused.
  always_comb begin
    prot_done = block_protect_flags;
    if (state == FPBS_BUSY && tmr_done && !op_fault) begin
      unique case (op)
        FPBS_OP_PROG: prot_done = block_protect_flags | sel_mask; // [RULE1]
        FPBS_OP_PAIR: prot_done = block_protect_flags & ~sel_mask; // [RULE13]
        FPBS_OP_FULL: prot_done = full_phase2 ? 4'h0 : block_protect_flags; // [RULE10]
        default: prot_done = block_protect_flags;
      endcase
    end
  end

  // Sequence and operation registers
  // Cycle counter advances only on accepted writes; the code is captured from any write at cycle 2.
  // The operation kind is latched at the seventh cycle, because the
  // flags that pick it may change once the operation is under way.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= FPBS_IDLE;
      cyc <= 3'h0;
      code <= 8'h00;
      op <= FPBS_OP_PROG;
      sel_mask <= 4'h0;
      full_phase2 <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      if (state == FPBS_IDLE && v && is_a_cyc) cyc <= 3'h1;
      else if (state == FPBS_UNLK && v) begin
        cyc <= cyc + 3'h1;
        if (cyc == 3'h2) code <= d;
      end
      if (state == FPBS_UNLK && seventh) begin
        // Erase mode is fixed by flags before the command ran
        if (code == `FPBS_PROG_CODE) begin
          op <= FPBS_OP_PROG;
          sel_mask <= one_bit;
        end else if (all_prot) begin
          op <= FPBS_OP_FULL; // [RULE8]
          sel_mask <= `FPBS_ALL_PROT;
        end else begin
          op <= FPBS_OP_PAIR;
          sel_mask <= pair_bits;
        end
        full_phase2 <= 1'b0;
      end
      if (state == FPBS_BUSY && tmr_done && op == FPBS_OP_FULL) full_phase2 <= 1'b1;
      if (next_state == FPBS_IDLE) cyc <= 3'h0;
    end
  end

  // Protection flags; only a hard reset aborts, and it clears them to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      block_protect_flags <= 4'h0;
    end else if (ce) begin
      block_protect_flags <= prot_done; // [RULE11]
    end
  end

  // Ready flag: low from the seventh cycle through the whole operation
  // It looks at next_state so that it falls on the edge that takes
  // the seventh write, with no extra cycle of apparent readiness.
  // A failed operation keeps it low; only rst brings it back.
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_busy_flag <= 1'b1;
    end else if (ce) begin
      ready_busy_flag <= (next_state != FPBS_BUSY) && (next_state != FPBS_FAIL); // [RULE7] [RULE15]
    end
  end

  // Array erase strobe when the first full-erase phase starts
  // One cycle wide; the array outside counts these strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      array_erase_pulse <= 1'b0;
    end else if (ce) begin
      array_erase_pulse <= (state == FPBS_UNLK) && seventh && (code == `FPBS_ERASE_CODE) && all_prot;
    end
  end

  // Access guards for the flash array
  // Both verdicts are registered, one cycle after the access shows up.
  // Trade-off: that cycle of latency keeps every output on a flip-flop.
  wire hit_block = |(target_block & block_protect_flags);
  always_ff @(posedge clk) begin
    if (rst) begin
      block_access_denied <= 1'b0;
      outside_read_denied <= 1'b0;
    end else if (ce) begin
      block_access_denied <= hit_block && (target_is_write || target_is_erase); // [RULE2]
      outside_read_denied <= outside_read && all_prot; // [RULE4]
    end
  end

  // Status word; writes here do nothing
  // Bits 3 and 1 are fixed zero; bit 2 is zero for a flash part
  // The upper 24 bits never carry anything
  // Reads of any other address return zero rather than stale data
  // Read data stand for exactly one cycle after the strobe
  wire [31:0] status_word = {24'h000000, block_protect_flags, 1'b0, 1'b0, 1'b0,
                             ready_busy_flag}; // [RULE16] [RULE17] [RULE21]
  wire csr_hit = rd_en && (addr == `FPBS_CSR_ADDR);
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= csr_hit ? status_word : 32'h0000_0000;
    end
  end
endmodule : fpbs_sequencer
`default_nettype wire

// ==== tb/fpbs_checker.sv ====
// Purpose: port-level checks on the protection-bit sequencer
// Assumes: one clock, ce held high
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module fpbs_checker
  import fpbs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [3:0] target_block,
  input wire logic target_is_write,
  input wire logic target_is_erase,
  input wire logic outside_read,
  input wire logic op_fault,
  input wire logic [31:0] rdata,
  input wire logic [3:0] block_protect_flags,
  input wire logic ready_busy_flag,
  input wire logic block_access_denied,
  input wire logic outside_read_denied
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Busy begins
  sequence op_start;
    $fell(ready_busy_flag);
  endsequence
  // Busy ends or a fault freezes it; bound keeps the check able to fail
  sequence op_end;
    ##[1:1000] (ready_busy_flag || op_fault);
  endsequence
  stat_read_a:
  assert property (!$past(rst) && $past(rd_en && addr == 32'h0) |-> rdata ==
    {24'h0, $past(block_protect_flags), 3'h0, $past(ready_busy_flag)}) else $error("bad status");
  flag_update_a:
  assert property (!$past(rst) && $changed(block_protect_flags) |-> $rose(ready_busy_flag))
    else $error("flags moved outside an op end");
  busy_frozen_a:
  assert property (!ready_busy_flag |-> $stable(block_protect_flags)) else $error("flags moved");
  busy_start_a:
  assert property (op_start |-> $past(wr_en) || $past(wr_en, 2)) else $error("busy w/o write");
  busy_hold_a:
  assert property (op_start |-> (!ready_busy_flag) [*3]) else $error("busy too short");
  busy_bound_a:
  assert property (op_start |-> op_end) else $error("busy never ends");
  fault_hold_a:
  assert property (!ready_busy_flag && op_fault |=> (!ready_busy_flag) [*8])
    else $error("ready after fault");
  outside_deny_a:
  assert property (!$past(rst) |-> outside_read_denied ==
    $past(outside_read && block_protect_flags == 4'hF)) else $error("outside read gate");
  block_deny_a:
  assert property (!$past(rst) |-> block_access_denied == $past((target_is_write ||
    target_is_erase) && (target_block & block_protect_flags) != 4'h0)) else $error("block gate");
endmodule : fpbs_checker
bind fpbs_sequencer fpbs_checker fpbs_checker_i (
  .clk(clk),
  .rst(rst),
  .addr(addr),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .target_block(target_block),
  .target_is_write(target_is_write),
  .target_is_erase(target_is_erase),
  .outside_read(outside_read),
  .op_fault(op_fault),
  .rdata(rdata),
  .block_protect_flags(block_protect_flags),
  .ready_busy_flag(ready_busy_flag),
  .block_access_denied(block_access_denied),
  .outside_read_denied(outside_read_denied)
);
`default_nettype wire

// ==== tb/fpbs_cpu_model.sv ====
// Purpose: CPU side issuing command writes and status reads
// Assumes: tasks are called from one process
// Notes: signals change by non-blocking assignment after an edge
`timescale 1ns/1ps
`default_nettype none
`include "fpbs_consts.svh"
module fpbs_cpu_model (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output logic [31:0] addr,
  output logic [31:0] wdata,
  output logic wr_en,
  output logic rd_en
);
  // Idle bus at time zero
  initial begin
    addr = 32'h0;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // One write, taken at the second edge; released bus shows inverted values
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : wr
  // Status read; data stand only in the cycle after the strobe
  task automatic rd(output logic [31:0] d);
    @(posedge clk);
    addr <= `FPBS_CSR_ADDR;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Seven-cycle command, spaced well apart
  task automatic cmd(input logic [7:0] code, input logic [1:0] sel);
    for (int i = 0; i < 7; i++) begin
      wr((i == 6) ? `FPBS_CMD_BASE + {26'h0, sel, 4'h0} :
        {16'h0, (i % 3 == 1) ? `FPBS_ADDR_B : `FPBS_ADDR_A}, {24'h0, (i % 3 == 2 || i == 6) ?
        code : (i % 3 == 1) ? `FPBS_UNLOCK_B : `FPBS_UNLOCK_A});
      repeat (15) @(posedge clk);
    end
  endtask : cmd
endmodule : fpbs_cpu_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the protection-bit sequencer
// Assumes: long operations shortened by parameters
// Notes: flag model kept in plain integers
`timescale 1ns/1ps
`default_nettype none
`include "fpbs_consts.svh"
module testbench
  import fpbs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] target_block = 4'h1;
  logic target_is_write = 1'b0;
  logic target_is_erase = 1'b0;
  logic outside_read = 1'b0;
  logic op_fault = 1'b0;
  logic [31:0] lf = 32'hFA4B88EC;
  logic [31:0] addr, wdata, rdata;
  logic wr_en, rd_en, ready_busy_flag, block_access_denied, outside_read_denied;
  logic array_erase_pulse;
  logic [3:0] block_protect_flags;
  int fails = 0, num_checks = 0, exp_flags = 0, pulses = 0;
  int order[$] = '{2, 0, 3, 1};
  int psel[$] = '{0, 2, 1, 2};
  // Busy time long enough to hold a whole ignored command
  fpbs_sequencer #(.PROG_CYCLES(400), .ARRAY_CYCLES(300), .PAIR_CYCLES(200)) fpbs_sequencer_i (.*);
  fpbs_cpu_model fpbs_cpu_model_i (.*);
  always #10 clk = ~clk;
  function automatic logic [31:0] lf_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lf_next
  // Random array traffic against the protection flags
  always @(posedge clk) begin
    lf <= lf_next(lf);
    target_block <= 4'h1 << lf[1:0];
    target_is_write <= lf[2];
    target_is_erase <= lf[3] & ~lf[2];
    outside_read <= lf[4];
    if (array_erase_pulse) pulses++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stat(input int f, input logic rdy);
    logic [31:0] s;
    fpbs_cpu_model_i.rd(s);
    check(s, {24'h0, f[3:0], 3'h0, rdy});
  endtask : stat
  // Bounded wait for the end of an operation
  task automatic wait_rdy;
    for (int n = 0; n < 2000 && ready_busy_flag !== 1'b1; n++) @(posedge clk);
  endtask : wait_rdy
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    #(60000 * 20);
    fails++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    stat(0, 1'b1);
    fpbs_cpu_model_i.wr(`FPBS_CSR_ADDR, lf);
    stat(0, 1'b1);
    $display("reset test done");
    // Program in shuffled order; one command lands on a busy sequencer
    foreach (order[k]) begin
      fpbs_cpu_model_i.cmd(`FPBS_PROG_CODE, order[k][1:0]);
      stat(exp_flags, 1'b0);
      if (k == 0) fpbs_cpu_model_i.cmd(`FPBS_PROG_CODE, 2'h3);
      wait_rdy;
      exp_flags |= 1 << order[k];
      stat(exp_flags, 1'b1);
    end
    fpbs_cpu_model_i.cmd(`FPBS_PROG_CODE, 2'h0);
    stat(15, 1'b1);
    $display("program test done");
    fpbs_cpu_model_i.cmd(`FPBS_ERASE_CODE, 2'h0);
    wait_rdy;
    exp_flags = 0;
    stat(0, 1'b1);
    check(pulses, 1);
    $display("full erase test done");
    // Partial program, then pair erases of each half
    for (int k = 0; k < 4; k++) begin
      fpbs_cpu_model_i.cmd(k < 2 ? `FPBS_PROG_CODE : `FPBS_ERASE_CODE, psel[k][1:0]);
      wait_rdy;
      if (k < 2) exp_flags |= 1 << psel[k];
      else exp_flags &= (psel[k] < 2) ? 12 : 3;
      stat(exp_flags, 1'b1);
    end
    check(pulses, 1);
    $display("pair erase test done");
    // Fault freezes busy until hardware reset
    fpbs_cpu_model_i.cmd(`FPBS_PROG_CODE, 2'h1);
    repeat (50) @(posedge clk);
    op_fault <= 1'b1;
    @(posedge clk);
    op_fault <= 1'b0;
    repeat (500) @(posedge clk);
    check(ready_busy_flag, 0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    stat(0, 1'b1);
    $display("fault test done");
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
